//--- dv/ssd_detector_test.sv
// self-checking bench of the scan setpoint detector
// assumes ssd_scan_model drives the scan stream; bench is the register host
module ssd_detector_test;
  timeunit 1ns;
  timeprecision 1ps;
  import ssd_pkg::*;

  logic              i_sys_clk;
  logic              i_resetn;
  logic [AW-1:0]     i_addr;
  logic [DW-1:0]     i_wdata;
  logic              i_wr;
  logic              i_rd;
  logic [DW-1:0]     o_rdata;
  ssd_scan_t         i_scan;
  ssd_scan_t         o_flag_sample;
  logic [NUM_SP-1:0] o_flags;
  logic [7:0]        o_port;
  ssd_tload_t        o_tload;
  int                miscompares;
  int                comparisons;
  int                seed;
  logic [31:0]       r;
  ssd_cfg_t          cfg [NUM_SP];
  logic [15:0]       la [NUM_SP];
  logic [15:0]       lb [NUM_SP];
  ssd_out_t          o1 [NUM_SP];
  ssd_out_t          o2 [NUM_SP];
  logic [NUM_SP-1:0] e_flags;
  logic [7:0]        e_port;
  ssd_tload_t        e_tl;
  ssd_scan_t         e_fs;
  logic              armed;
  logic [7:0]        flagch;
  logic [15:0]       x;

  ssd_detector dut (
    .i_sys_clk(i_sys_clk), .i_resetn(i_resetn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_scan(i_scan), .o_flag_sample(o_flag_sample), .o_flags(o_flags),
    .o_port(o_port), .o_tload(o_tload)
  );
  ssd_scan_model seq (.i_sys_clk(i_sys_clk), .o_scan(i_scan));

  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end

  task automatic end_sim;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge i_sys_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_sys_clk);
    i_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] e);
    @(posedge i_sys_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_sys_clk);
    i_rd   <= 1'b0;
    #1 chk("rdata", e, o_rdata);
    @(posedge i_sys_clk);
    #1 chk("rdata_idle", '0, o_rdata);
  endtask

  function automatic logic cond(ssd_crit_t c, logic [15:0] v, a, b);
    case (c)
      SSD_CRIT_INSIDE:  return v > b && v < a;
      SSD_CRIT_OUTSIDE: return v > a || v < b;
      SSD_CRIT_GT:      return v > b;
      SSD_CRIT_LT:      return v < a;
      default:          return v == a;
    endcase
  endfunction

  function automatic void apply(ssd_tgt_t t, ssd_out_t v);
    if (t == SSD_TGT_PORT) e_port = (e_port & ~v.mask) | (v.data & v.mask);
    else if (t != SSD_TGT_NONE) e_tl = '{1'b1, t == SSD_TGT_TMR1, v.timer};
  endfunction

  function automatic void predict(logic [7:0] ch, logic [15:0] v);
    logic c;
    e_tl = '0;
    e_fs = (ch == flagch) ? ssd_scan_t'{1'b1, flagch, e_flags} : '0;
    if (!armed) return;
    for (int n = 0; n < NUM_SP; n++)
      if (cfg[n].en && cfg[n].chan == ch) begin
        if (cfg[n].mode == SSD_MODE_HYST) begin
          if (v > la[n]) begin
            e_flags[n] = 1'b1;
            apply(cfg[n].tgt, o2[n]);
          end else if (v < lb[n]) begin
            e_flags[n] = 1'b0;
            apply(cfg[n].tgt, o1[n]);
          end
        end else begin
          c = cond(cfg[n].crit, v, la[n], lb[n]);
          e_flags[n] = c;
          if (c) apply(cfg[n].tgt, o1[n]);
          else if (cfg[n].mode == SSD_MODE_TRUE_FALSE) apply(cfg[n].tgt, o2[n]);
        end
        return;
      end
  endfunction

  task automatic word(input logic [7:0] ch, input logic [15:0] v);
    predict(ch, v);
    r = $random(seed);
    seq.send(ch, v, int'(r[1:0]));
    #1;
    chk("flags", e_flags, o_flags);
    chk("port", e_port, o_port);
    chk("tload", e_tl, o_tload);
    chk("flag_sample", e_fs, o_flag_sample);
  endtask

  task automatic prog(input logic [3:0] n, input ssd_cfg_t c);
    cfg[n] = c;
    la[n]  = $random(seed);
    lb[n]  = $random(seed);
    o1[n]  = $random(seed);
    o2[n]  = $random(seed);
    wr({SP_PAGE, n, OFS_CFG}, {16'h0000, c});
    wr({SP_PAGE, n, OFS_LIM}, {la[n], lb[n]});
    wr({SP_PAGE, n, OFS_OUT1}, o1[n]);
    wr({SP_PAGE, n, OFS_OUT2}, o2[n]);
  endtask

  initial begin
    #200_000;
    miscompares++;
    end_sim();
  end

  initial begin
    seed = 32'h9b04;
    {i_resetn, i_wr, i_rd, i_addr, i_wdata} = '0;
    {miscompares, comparisons, armed} = '0;
    e_flags = '0;
    e_port  = PORT_RST;
    flagch  = FLAGCH_RST;
    repeat (6) @(posedge i_sys_clk);
    i_resetn <= 1'b1;
    #1 chk("port_rst", PORT_RST, o_port);
    rd(ADDR_FLAGCH, {24'h00_0000, FLAGCH_RST});
    rd(ADDR_CTRL, 32'h0000_0000);
    rd(12'h010, 32'h0000_0000);
    wr(ADDR_PORT, 32'h0000_005a);
    e_port = 8'h5a;
    rd(ADDR_PORT, 32'h0000_005a);
    for (int n = 0; n < NUM_SP; n++)
      prog(4'(n), '{1'b1, (n == 13) ? 8'h40 : (n == 14) ? 8'h41 :
           (n == 15) ? 8'h01 : 8'(n + 1), ssd_crit_t'(n % 5),
           (n >= 10 && n < 13) ? SSD_MODE_HYST :
           n[0] ? SSD_MODE_TRUE_FALSE : SSD_MODE_TRUE_ONLY,
           ssd_tgt_t'(n % 4)});
    word(8'h01, la[0]);
    wr(ADDR_CTRL, 32'h0000_0001);
    armed = 1'b1;
    wr({SP_PAGE, 4'h0, OFS_CFG}, 32'h0000_0000);
    rd({SP_PAGE, 4'h0, OFS_CFG}, {16'h0000, cfg[0]});
    wr(ADDR_FLAGCH, 32'h0000_0030);
    flagch = 8'h30;
    for (int i = 0; i < 400; i++) begin
      r = $random(seed);
      x = $random(seed);
      case (r[6:4])
        3'd0: x = la[r[3:0]];
        3'd1: x = la[r[3:0]] + 16'h0001;
        3'd2: x = la[r[3:0]] - 16'h0001;
        3'd3: x = lb[r[3:0]];
        3'd4: x = lb[r[3:0]] + 16'h0001;
        3'd5: x = lb[r[3:0]] - 16'h0001;
        default: ;
      endcase
      word(r[9:7] == 3'd0 ? 8'h77 : cfg[r[3:0]].chan, x);
      if (i % 16 == 15) begin
        word(flagch, x);
        rd(ADDR_STATUS, {16'h0000, e_flags});
      end
    end
    end_sim();
  end
endmodule // ssd_detector_test

//--- dv/ssd_scan_model.sv
// scan sequencer model: hands the detector one channel word per request
// assumes the detector samples i_scan on the rising edge of i_sys_clk
module ssd_scan_model (
  input  wire logic          i_sys_clk,
  output ssd_pkg::ssd_scan_t o_scan
);
  timeunit 1ns;
  timeprecision 1ps;
  import ssd_pkg::*;

  initial o_scan = '0;

  // idle slots first, then one word for one edge; released lines invert
  task automatic send(input logic [7:0] ch, input logic [15:0] d,
                      input int idle);
    repeat (idle) @(posedge i_sys_clk);
    @(posedge i_sys_clk);
    o_scan <= '{valid: 1'b1, chan: ch, data: d};
    @(posedge i_sys_clk);
    o_scan <= '{valid: 1'b0, chan: ~ch, data: ~d};
  endtask
endmodule // ssd_scan_model

//--- src/ssd_compare.sv
// window and single-limit comparison of one 16-bit channel word
// assumes unsigned words; combinational, no state
module ssd_compare (
  input  wire logic [15:0]       i_sample,
  input  wire logic [15:0]       i_lim_a,
  input  wire logic [15:0]       i_lim_b,
  input  wire ssd_pkg::ssd_crit_t i_crit,
  output logic                   o_cond,
  output logic                   o_above,
  output logic                   o_below
);
  import ssd_pkg::*;

  // word meaning is irrelevant here
  assign o_above = i_sample > i_lim_a;
  assign o_below = i_sample < i_lim_b;

  always_comb begin
    case (i_crit)
      SSD_CRIT_INSIDE:  o_cond = (i_sample > i_lim_b) && (i_sample < i_lim_a);
      SSD_CRIT_OUTSIDE: o_cond = o_above || o_below;
      SSD_CRIT_GT:      o_cond = i_sample > i_lim_b;
      SSD_CRIT_LT:      o_cond = i_sample < i_lim_a;
      SSD_CRIT_EQ:      o_cond = i_sample == i_lim_a;
      default:          o_cond = 1'b0;
    endcase
  end

endmodule // ssd_compare

//--- src/ssd_detector.sv
// scan setpoint detector: per-channel compare, detect flags, output updates
// assumes a scan sequencer on the same clock presenting one word per cycle
//
// Local design decisions: the placing of the registers and strobed register access.
module ssd_detector (
  input  wire logic                 i_sys_clk,
  input  wire logic                 i_resetn,
  input  wire logic [ssd_pkg::AW-1:0] i_addr,
  input  wire logic [ssd_pkg::DW-1:0] i_wdata,
  input  wire logic                 i_wr,
  input  wire logic                 i_rd,
  output logic      [ssd_pkg::DW-1:0] o_rdata,
  input  wire ssd_pkg::ssd_scan_t   i_scan,
  output ssd_pkg::ssd_scan_t        o_flag_sample,
  output logic      [ssd_pkg::NUM_SP-1:0] o_flags,
  output logic      [7:0]           o_port,
  output ssd_pkg::ssd_tload_t       o_tload
);
  import ssd_pkg::*;

  typedef struct packed {
    ssd_cfg_t   [NUM_SP-1:0] cfg;
    logic       [NUM_SP-1:0][15:0] lim_a;
    logic       [NUM_SP-1:0][15:0] lim_b;
    ssd_out_t   [NUM_SP-1:0] out1;
    ssd_out_t   [NUM_SP-1:0] out2;
    logic       [NUM_SP-1:0] flags;
    logic                    arm;
    logic       [7:0]        flag_chan;
    logic       [7:0]        port;
    ssd_tload_t              tload;
    ssd_scan_t               flag_sample;
    logic       [DW-1:0]     rdata;
  } ssd_state_t;

  ssd_state_t st_r;
  ssd_state_t st_nxt;

  // setpoint page decode, shared by read and write
  function automatic logic sp_page(input logic [AW-1:0] a);
    return a[11:8] == SP_PAGE;
  endfunction

  // lowest matching setpoint owns the channel word
  function automatic logic [4:0] sp_match(input ssd_cfg_t [NUM_SP-1:0] c,
                                          input logic [7:0] ch);
    logic [4:0] r;
    r = 5'h00;
    for (int i = NUM_SP - 1; i >= 0; i--) begin
      if (c[i].en && c[i].chan == ch) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction

  // masked byte merge of a port update
  function automatic logic [7:0] merge(input logic [7:0] old,
                                       input ssd_out_t o);
    return (old & ~o.mask) | (o.data & o.mask);
  endfunction

  logic [4:0]  match;
  logic        hit;
  logic [3:0]  idx;
  logic        eval;
  logic        cond;
  logic        above;
  logic        below;
  ssd_cfg_t    cur;
  logic [3:0]  sp_w;

  assign match = sp_match(st_r.cfg, i_scan.chan);
  assign hit   = match[4];
  assign idx   = match[3:0];
  assign cur   = st_r.cfg[idx];
  assign eval  = i_scan.valid && st_r.arm && hit;
  assign sp_w  = i_addr[7:4];

  ssd_compare u_cmp (
    .i_sample (i_scan.data),
    .i_lim_a  (st_r.lim_a[idx]),
    .i_lim_b  (st_r.lim_b[idx]),
    .i_crit   (cur.crit),
    .o_cond   (cond),
    .o_above  (above),
    .o_below  (below)
  );

  always_comb begin
    ssd_out_t act;
    logic     apply;
    act               = '0;
    apply             = 1'b0;
    st_nxt            = st_r;
    st_nxt.rdata      = '0;
    st_nxt.tload      = '0;
    st_nxt.flag_sample = '0;

    // register writes; setpoint tables frozen while armed
    if (i_wr) begin
      if (i_addr == ADDR_CTRL) begin
        st_nxt.arm = i_wdata[CTRL_ARM_POS];
        if (i_wdata[CTRL_ARM_POS] && !st_r.arm) begin
          st_nxt.flags = '0;
        end
      end else if (i_addr == ADDR_PORT) begin
        st_nxt.port = i_wdata[7:0];
      end else if (i_addr == ADDR_FLAGCH) begin
        st_nxt.flag_chan = i_wdata[7:0];
      end else if (sp_page(i_addr) && !st_r.arm) begin
        case (i_addr[3:0])
          OFS_CFG: st_nxt.cfg[sp_w] = ssd_cfg_t'(i_wdata[15:0]);
          OFS_LIM: begin
            st_nxt.lim_a[sp_w] = i_wdata[LIM_A_LSB +: 16];
            st_nxt.lim_b[sp_w] = i_wdata[15:0];
          end
          OFS_OUT1: st_nxt.out1[sp_w] = ssd_out_t'(i_wdata);
          OFS_OUT2: st_nxt.out2[sp_w] = ssd_out_t'(i_wdata);
          default: ;
        endcase
      end
    end

    // register reads, data in the following cycle only
    if (i_rd) begin
      if (i_addr == ADDR_CTRL) begin
        st_nxt.rdata = {31'h0000_0000, st_r.arm};
      end else if (i_addr == ADDR_STATUS) begin
        st_nxt.rdata = {16'h0000, st_r.flags};
      end else if (i_addr == ADDR_PORT) begin
        st_nxt.rdata = {24'h00_0000, st_r.port};
      end else if (i_addr == ADDR_FLAGCH) begin
        st_nxt.rdata = {24'h00_0000, st_r.flag_chan};
      end else if (sp_page(i_addr)) begin
        case (i_addr[3:0])
          OFS_CFG:  st_nxt.rdata = {16'h0000, st_r.cfg[sp_w]};
          OFS_LIM:  st_nxt.rdata = {st_r.lim_a[sp_w], st_r.lim_b[sp_w]};
          OFS_OUT1: st_nxt.rdata = st_r.out1[sp_w];
          OFS_OUT2: st_nxt.rdata = st_r.out2[sp_w];
          default:  st_nxt.rdata = '0;
        endcase
      end
    end

    // detect flags returned as a channel word when that slot is scanned
    if (i_scan.valid && i_scan.chan == st_r.flag_chan) begin
      st_nxt.flag_sample = {1'b1, st_r.flag_chan, st_r.flags};
    end

    // evaluation in the source channel's slot
    if (eval) begin
      if (cur.mode == SSD_MODE_HYST) begin
        if (above) begin
          st_nxt.flags[idx] = 1'b1;
          act   = st_r.out2[idx];
          apply = 1'b1;
        end else if (below) begin
          st_nxt.flags[idx] = 1'b0;
          act   = st_r.out1[idx];
          apply = 1'b1;
        end
      end else begin
        st_nxt.flags[idx] = cond;
        if (cond) begin
          act   = st_r.out1[idx];
          apply = 1'b1;
        end else if (cur.mode == SSD_MODE_TRUE_FALSE) begin
          act   = st_r.out2[idx];
          apply = 1'b1;
        end
      end
    end

    // output update: port byte or timer reload
    if (apply) begin
      case (cur.tgt)
        SSD_TGT_PORT: st_nxt.port = merge(st_r.port, act);
        SSD_TGT_TMR0: st_nxt.tload = {1'b1, 1'b0, act.timer};
        SSD_TGT_TMR1: st_nxt.tload = {1'b1, 1'b1, act.timer};
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_r           <= '0;
      st_r.arm       <= ARM_RST;
      st_r.port      <= PORT_RST;
      st_r.flag_chan <= FLAGCH_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_rdata       = st_r.rdata;
  assign o_flags       = st_r.flags;
  assign o_port        = st_r.port;
  assign o_tload       = st_r.tload;
  assign o_flag_sample = st_r.flag_sample;

  // assertions

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_resetn);

  a_inside_crit: assert property (
    eval && cur.crit == SSD_CRIT_INSIDE |->
      cond == (i_scan.data > st_r.lim_b[idx] &&
               i_scan.data < st_r.lim_a[idx]))
    else $error("inside criterion wrong");

  a_outside_crit: assert property (
    eval && cur.crit == SSD_CRIT_OUTSIDE |->
      cond == (i_scan.data > st_r.lim_a[idx] ||
               i_scan.data < st_r.lim_b[idx]))
    else $error("outside criterion wrong");

  a_greater_crit: assert property (
    eval && cur.crit == SSD_CRIT_GT |->
      cond == (i_scan.data > st_r.lim_b[idx]))
    else $error("greater-than criterion wrong");

  a_less_crit: assert property (
    eval && cur.crit == SSD_CRIT_LT |->
      cond == (i_scan.data < st_r.lim_a[idx]))
    else $error("less-than criterion wrong");

  a_equal_crit: assert property (
    eval && cur.crit == SSD_CRIT_EQ |->
      cond == (i_scan.data == st_r.lim_a[idx]))
    else $error("equal criterion wrong");

  a_flag_follows: assert property (
    eval && cur.mode != SSD_MODE_HYST |=>
      o_flags[$past(idx)] == $past(cond))
    else $error("detect flag does not follow condition");

  a_flag_cause: assert property (
    !$stable(o_flags) |->
      $past(eval) || $past(i_wr && i_addr == ADDR_CTRL))
    else $error("detect flag moved outside its slot");

  a_true_only_idle: assert property (
    eval && cur.mode == SSD_MODE_TRUE_ONLY && !cond && !i_wr |=>
      $stable(o_port) && !o_tload.valid)
    else $error("true-only mode acted on false");

  a_false_value: assert property (
    eval && cur.mode == SSD_MODE_TRUE_FALSE && !cond &&
    (cur.tgt == SSD_TGT_TMR0 || cur.tgt == SSD_TGT_TMR1) |=>
      o_tload.valid &&
      o_tload.sel == $past(cur.tgt == SSD_TGT_TMR1) &&
      o_tload.value == $past(st_r.out2[idx].timer))
    else $error("false did not load output 2");

  a_hyst_high: assert property (
    eval && cur.mode == SSD_MODE_HYST && above |=>
      o_flags[$past(idx)])
    else $error("hysteresis high not forced");

  a_hyst_hold: assert property (
    eval && cur.mode == SSD_MODE_HYST && !above && !below &&
    !(i_wr && i_addr == ADDR_CTRL) |=> $stable(o_flags))
    else $error("hysteresis changed inside window");

  a_port_mask: assert property (
    eval && cur.mode != SSD_MODE_HYST && cond &&
    cur.tgt == SSD_TGT_PORT && !i_wr |=>
      ((o_port ^ $past(st_r.port)) & ~$past(st_r.out1[idx].mask)) == 8'h00)
    else $error("unmasked port bit changed");

  a_status_read: assert property (
    i_rd && i_addr == ADDR_STATUS |=>
      o_rdata == {16'h0000, $past(o_flags)})
    else $error("status word wrong");

  a_rdata_idle: assert property (
    !i_rd |=> o_rdata == 32'h0000_0000)
    else $error("read data outside its cycle");

  a_true_value: assert property (
    eval && cur.mode != SSD_MODE_HYST && cond &&
    (cur.tgt == SSD_TGT_TMR0 || cur.tgt == SSD_TGT_TMR1) |=>
      o_tload.valid &&
      o_tload.value == $past(st_r.out1[idx].timer))
    else $error("true did not load output 1");

  a_hyst_low: assert property (
    eval && cur.mode == SSD_MODE_HYST && !above && below |=>
      !o_flags[$past(idx)])
    else $error("hysteresis low not forced");

  a_hyst_quiet: assert property (
    eval && cur.mode == SSD_MODE_HYST && !above && !below &&
    !i_wr |=> $stable(o_port) && !o_tload.valid)
    else $error("hysteresis acted inside window");

  a_unarmed_idle: assert property (
    i_scan.valid && !st_r.arm && !i_wr |=>
      $stable(o_flags) && $stable(o_port) && !o_tload.valid)
    else $error("disarmed detector acted");

  a_unmatched_idle: assert property (
    i_scan.valid && !hit && !i_wr |=>
      $stable(o_flags) && $stable(o_port) && !o_tload.valid)
    else $error("unmatched channel word acted");

  a_flag_word: assert property (
    i_scan.valid && i_scan.chan == st_r.flag_chan |=>
      o_flag_sample.valid && o_flag_sample.data == $past(o_flags) &&
      o_flag_sample.chan == $past(st_r.flag_chan))
    else $error("flag word wrong");

  a_flag_word_idle: assert property (
    !(i_scan.valid && i_scan.chan == st_r.flag_chan) |=>
      !o_flag_sample.valid)
    else $error("flag word without its slot");

  a_table_frozen: assert property (
    i_wr && sp_page(i_addr) && st_r.arm |=>
      $stable(st_r.cfg) && $stable(st_r.lim_a) && $stable(st_r.lim_b))
    else $error("setpoint table written while armed");

  a_owner_match: assert property (
    eval |-> cur.en && cur.chan == i_scan.chan)
    else $error("word evaluated by wrong setpoint");

  a_port_data: assert property (
    eval && cur.mode != SSD_MODE_HYST && cond &&
    cur.tgt == SSD_TGT_PORT |=>
      (o_port & $past(st_r.out1[idx].mask)) ==
      ($past(st_r.out1[idx].data) & $past(st_r.out1[idx].mask)))
    else $error("masked port bits not updated");

  a_tload_cause: assert property (
    !eval |=> !o_tload.valid)
    else $error("timer load without evaluation");

  a_port_hold: assert property (
    !eval && !i_wr |=> $stable(o_port))
    else $error("port moved without update");

  c_hyst_high: cover property (eval && cur.mode == SSD_MODE_HYST && above);
  c_port_tf: cover property (
    eval && cur.mode == SSD_MODE_TRUE_FALSE && cur.tgt == SSD_TGT_PORT);
  c_equal_hit: cover property (eval && cur.crit == SSD_CRIT_EQ && cond);
  c_status_rd: cover property (i_rd && i_addr == ADDR_STATUS ##1 |o_rdata);
  c_tmr_false: cover property (eval && cur.mode == SSD_MODE_TRUE_FALSE &&
    !cond && cur.tgt == SSD_TGT_TMR1);

endmodule // ssd_detector

//--- src/ssd_pkg.sv
// constants and types of the scan setpoint detector
// assumes one 100 MHz clock domain shared with the scan sequencer
package ssd_pkg;

  localparam int NUM_SP = 16;
  localparam int AW     = 12;
  localparam int DW     = 32;

  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_PORT   = 12'h008;
  localparam logic [11:0] ADDR_FLAGCH = 12'h00c;
  localparam logic [3:0]  SP_PAGE     = 4'h1;
  localparam logic [3:0]  OFS_CFG     = 4'h0;
  localparam logic [3:0]  OFS_LIM     = 4'h4;
  localparam logic [3:0]  OFS_OUT1    = 4'h8;
  localparam logic [3:0]  OFS_OUT2    = 4'hc;

  localparam int CTRL_ARM_POS = 0;
  localparam int LIM_A_LSB    = 16;

  localparam logic       ARM_RST    = 1'b0;
  localparam logic [7:0] PORT_RST   = 8'h00;
  localparam logic [7:0] FLAGCH_RST = 8'hff;

  typedef enum logic [2:0] {
    SSD_CRIT_INSIDE  = 3'h0,
    SSD_CRIT_OUTSIDE = 3'h1,
    SSD_CRIT_GT      = 3'h2,
    SSD_CRIT_LT      = 3'h3,
    SSD_CRIT_EQ      = 3'h4
  } ssd_crit_t;

  typedef enum logic [1:0] {
    SSD_MODE_TRUE_ONLY  = 2'h0,
    SSD_MODE_TRUE_FALSE = 2'h1,
    SSD_MODE_HYST       = 2'h3
  } ssd_mode_t;

  typedef enum logic [1:0] {
    SSD_TGT_NONE = 2'h0,
    SSD_TGT_PORT = 2'h1,
    SSD_TGT_TMR0 = 2'h2,
    SSD_TGT_TMR1 = 2'h3
  } ssd_tgt_t;

  // cfg word: en[15] chan[14:7] crit[6:4] mode[3:2] tgt[1:0]
  typedef struct packed {
    logic       en;
    logic [7:0] chan;
    ssd_crit_t  crit;
    ssd_mode_t  mode;
    ssd_tgt_t   tgt;
  } ssd_cfg_t;

  typedef struct packed {
    logic [15:0] timer;
    logic [7:0]  mask;
    logic [7:0]  data;
  } ssd_out_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  chan;
    logic [15:0] data;
  } ssd_scan_t;

  typedef struct packed {
    logic        valid;
    logic        sel;
    logic [15:0] value;
  } ssd_tload_t;

endpackage : ssd_pkg
